// [rtl/stt_pkg.sv]
// Purpose: shared constants and types for the STS-12 overhead framer
// Assumes: byte-interleaved STS-12, one byte per clock when valid
// Notes:   positions are row, column group and STS-1 index in the group
package stt_pkg;

  // ==========================================================================
  // frame geometry
  localparam int unsigned ROWS      = 9;
  localparam int unsigned GROUPS    = 90;
  localparam int unsigned STS_N     = 12;
  localparam int unsigned TOH_GRPS  = 3;
  localparam int unsigned FRAME_LEN = ROWS * GROUPS * STS_N; // 9720 bytes

  // ==========================================================================
  // counter limits at counter width
  localparam logic [3:0] ROW_LAST = 4'h8;
  localparam logic [6:0] GRP_LAST = 7'h59;
  localparam logic [3:0] STS_LAST = 4'hb;
  localparam logic [6:0] SOH_ROWS = 7'h03;

  // ==========================================================================
  // fixed overhead values and reset values
  localparam logic [7:0] A1_VAL    = 8'hf6;
  localparam logic [7:0] A2_VAL    = 8'h28;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] BIP_RST   = 8'h00;

  // ==========================================================================
  // overhead byte kinds
  typedef enum logic [3:0] {
    CAT_PAY,
    CAT_A1,
    CAT_A2,
    CAT_B1,
    CAT_B1Z,
    CAT_H3,
    CAT_B2,
    CAT_K,
    CAT_S1,
    CAT_M0,
    CAT_TOH
  } stt_cat_e;

  // one stream byte with its frame marker
  typedef struct packed {
    logic [7:0] data;
    logic       mark;
  } stt_byte_s;

  // stream position
  typedef struct packed {
    logic [3:0] row;
    logic [6:0] grp;
    logic [3:0] sts;
  } stt_pos_s;

endpackage

// [rtl/stt_framer.sv]
// Purpose: transmit transparent overhead framer and receive overhead strip
// Assumes: fabric byte stream already frame aligned to the frame pulse
// Notes:   serial overhead port, scrambler and pointer mover live elsewhere
`timescale 1ns/1ps

// Notes on behaviour
// - every A1 slot carries f6, every A2 slot carries 28.
// - section parity of one frame goes to next frame B1, first STS-1.
// - B1 overwritten, the eleven bytes after it forced to zero.
// - H3 passes through; zero without justification, extra byte otherwise.
// - B2 is even BIP-8 over line bytes, per STS-1, next frame.
// - S1 only in first STS-1, status code in bits 5 to 8.
// - M0 bits 5 to 8 carry the line remote error count.
// - transmit only touches framing, parity, S1 and M0 bytes, rest forwarded.
// - receive removes overhead bytes from the payload stream.
// - receive presents regenerated framing bytes to the fabric.
// - receive K1/K2 pass through or are zeroed by a control input.
// - serial overhead block runs on its own 25 to 106 MHz clock.
// - transparent mode forwards all other bytes unchanged.
// - A1 and A2 always regenerated whatever the input holds.
// - bytes go out row by row, left to right, MSB first.
module stt_framer (
  // clock and reset
  input  logic              clk_i,
  input  logic              rstn_i,
  // transmit stream in, mark is the system frame pulse
  input  stt_pkg::stt_byte_s tx_in_i,
  input  logic              tx_in_valid_i,
  output logic              tx_in_ready_o,
  // transmit stream out, mark flags the first A1 byte
  output stt_pkg::stt_byte_s tx_out_o,
  output logic              tx_out_valid_o,
  input  logic              tx_out_ready_i,
  // transmit overhead control
  input  logic              sync_status_en_i,
  input  logic [3:0]        sync_status_i,
  input  logic              line_rei_en_i,
  input  logic [3:0]        line_rei_i,
  // receive stream in, mark is the receive frame start
  input  stt_pkg::stt_byte_s rx_in_i,
  input  logic              rx_in_valid_i,
  input  logic              rx_k_zero_i,
  // receive stream out, mark flags a payload byte
  output stt_pkg::stt_byte_s rx_out_o,
  output logic              rx_out_valid_o
);
  import stt_pkg::*;

  // ==========================================================================
  // helpers

  // kind of byte at a given position, shared by both directions
  function automatic stt_cat_e pos_cat(input stt_pos_s p);
    stt_cat_e c;
    c = CAT_PAY;
    if (p.grp < 7'(TOH_GRPS))
    begin
      c = CAT_TOH;
      unique case (p.row)
        4'h0:
          if (p.grp == 7'h0)
            c = CAT_A1;
          else if (p.grp == 7'h1)
            c = CAT_A2;
        4'h1:
          if (p.grp == 7'h0)
            c = (p.sts == 4'h0) ? CAT_B1 : CAT_B1Z;
        4'h3:
          if (p.grp == 7'h2)
            c = CAT_H3;
        4'h4:
          if (p.grp == 7'h0)
            c = CAT_B2;
          else
            c = CAT_K;
        4'h8:
          if (p.sts == 4'h0 && p.grp == 7'h0)
            c = CAT_S1;
          else if (p.sts == 4'h0 && p.grp == 7'h1)
            c = CAT_M0;
        default:
          c = CAT_TOH;
      endcase
    end
    return c;
  endfunction

  // next position, sts fastest, then group, then row
  function automatic stt_pos_s pos_step(input stt_pos_s p);
    stt_pos_s n;
    n = p;
    if (p.sts != STS_LAST)
      n.sts = p.sts + 4'h1;
    else
    begin
      n.sts = 4'h0;
      if (p.grp != GRP_LAST)
        n.grp = p.grp + 7'h1;
      else
      begin
        n.grp = 7'h0;
        n.row = (p.row == ROW_LAST) ? 4'h0 : p.row + 4'h1;
      end
    end
    return n;
  endfunction

  function automatic logic pos_last(input stt_pos_s p);
    return p.row == ROW_LAST && p.grp == GRP_LAST && p.sts == STS_LAST;
  endfunction

  // ==========================================================================
  // transmit position tracking

  stt_pos_s     tx_pos;
  stt_pos_s     tx_cur;
  stt_cat_e     tx_cat;
  logic         tx_push;
  logic         tx_first;
  logic         tx_last;
  logic         tx_line;
  stt_byte_s    next_tx;

  assign tx_push  = tx_in_valid_i && tx_in_ready_o;
  assign tx_cur   = tx_in_i.mark ? stt_pos_s'('0) : tx_pos;
  assign tx_cat   = pos_cat(tx_cur);
  assign tx_first = tx_cur == stt_pos_s'('0);
  assign tx_last  = pos_last(tx_cur);
  // line parity skips only the section overhead bytes, groups 0 to 2 of rows 0 to 2
  assign tx_line  = !(tx_cur.grp < 7'(TOH_GRPS) &&
                      {3'h0, tx_cur.row} < SOH_ROWS);

  // the pulse pins the byte it comes with to the first A1 slot
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      tx_pos <= '0;
    else if (tx_push)
      tx_pos <= pos_step(tx_cur);
  end

  // ==========================================================================
  // parity accumulators

  logic [7:0]   b1_acc;
  logic [7:0]   b1_prev;
  logic [7:0]   b2_acc  [STS_N];
  logic [7:0]   b2_prev [STS_N];

  // section parity over every byte as sent; restarts at each frame start
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      b1_acc  <= BIP_RST;
      b1_prev <= BIP_RST;
    end
    else if (tx_push)
    begin
      b1_acc <= (tx_first ? BIP_RST : b1_acc) ^ next_tx.data;
      if (tx_last)
        b1_prev <= b1_acc ^ next_tx.data;
    end
  end

  // one line parity per STS-1, selected by the interleave index
  genvar gi;
  generate
    for (gi = 0; gi < STS_N; gi++)
    begin : g_b2
      logic sel;
      assign sel = tx_cur.sts == 4'(gi);
      always_ff @(posedge clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          b2_acc[gi]  <= BIP_RST;
          b2_prev[gi] <= BIP_RST;
        end
        else if (tx_push)
        begin
          if (tx_first)
            b2_acc[gi] <= BIP_RST;
          else if (sel && tx_line)
            b2_acc[gi] <= b2_acc[gi] ^ next_tx.data;
          if (tx_last)
            b2_prev[gi] <= b2_acc[gi] ^
              ((sel && tx_line) ? next_tx.data : ZERO_BYTE);
        end
      end
    end
  endgenerate

  // ==========================================================================
  // transmit byte rewrite; only framing, parity, S1 and M0 slots are changed

  always_comb
  begin
    next_tx.data = tx_in_i.data;
    next_tx.mark = tx_first;
    unique case (tx_cat)
      CAT_A1:  next_tx.data = A1_VAL;
      CAT_A2:  next_tx.data = A2_VAL;
      CAT_B1:  next_tx.data = b1_prev;
      CAT_B1Z: next_tx.data = ZERO_BYTE;
      CAT_B2:  next_tx.data = b2_prev[tx_cur.sts];
      CAT_S1:
        if (sync_status_en_i)
          next_tx.data = {tx_in_i.data[7:4], sync_status_i};
      CAT_M0:
        if (line_rei_en_i)
          next_tx.data = {tx_in_i.data[7:4], line_rei_i};
      // H3 is the fabric's: zero, or the extra byte on negative justify
      CAT_H3:  next_tx.data = tx_in_i.data;
      default: next_tx.data = tx_in_i.data;
    endcase
  end

  // ==========================================================================
  // two-entry output buffer; a stall parks one word in the spare slot

  stt_byte_s    skid;
  logic         skid_valid;

  // ready is registered: it drops in the cycle the spare slot fills,
  // so no push is ever offered while the spare is occupied
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tx_out_o       <= '0;
      tx_out_valid_o <= 1'b0;
      skid           <= '0;
      skid_valid     <= 1'b0;
      tx_in_ready_o  <= 1'b1;
    end
    else if (!tx_out_valid_o || tx_out_ready_i)
    begin
      // head is free: refill from spare first so order holds
      tx_out_valid_o <= skid_valid || tx_push;
      tx_out_o       <= skid_valid ? skid : next_tx;
      skid_valid     <= 1'b0;
      tx_in_ready_o  <= 1'b1;
    end
    else if (tx_push)
    begin
      skid          <= next_tx;
      skid_valid    <= 1'b1;
      tx_in_ready_o <= 1'b0;
    end
  end

  // ==========================================================================
  // receive path: overhead removed, framing regenerated

  stt_pos_s     rx_pos;
  stt_pos_s     rx_cur;
  stt_cat_e     rx_cat;

  assign rx_cur = rx_in_i.mark ? stt_pos_s'('0) : rx_pos;
  assign rx_cat = pos_cat(rx_cur);

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rx_pos <= '0;
    else if (rx_in_valid_i)
      rx_pos <= pos_step(rx_cur);
  end

  // one cycle of latency; mark out says the byte is payload
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rx_out_o       <= '0;
      rx_out_valid_o <= 1'b0;
    end
    else
    begin
      rx_out_valid_o <= rx_in_valid_i;
      rx_out_o.mark  <= rx_cat == CAT_PAY;
      unique case (rx_cat)
        CAT_PAY: rx_out_o.data <= rx_in_i.data;
        CAT_A1:  rx_out_o.data <= A1_VAL;
        CAT_A2:  rx_out_o.data <= A2_VAL;
        // H3 must reach the pointer mover untouched; H1 and H2 go out as zero
        CAT_H3:  rx_out_o.data <= rx_in_i.data;
        CAT_K:
          rx_out_o.data <= rx_k_zero_i ? ZERO_BYTE : rx_in_i.data;
        default: rx_out_o.data <= ZERO_BYTE;
      endcase
    end
  end

  // ==========================================================================
  // checks

  AST_A1_VALUE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tx_push && tx_in_i.mark |-> next_tx.data == A1_VAL && next_tx.mark)
    else $error("first byte after frame pulse is not A1");

  AST_A2_VALUE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tx_push && tx_cat == CAT_A2 |-> next_tx.data == A2_VAL)
    else $error("A2 slot not regenerated");

  AST_B1_ZERO: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tx_push && tx_cur.row == 4'h1 && tx_cur.grp == 7'h0 &&
      tx_cur.sts != 4'h0 |-> next_tx.data == ZERO_BYTE)
    else $error("byte after B1 not zero");

  AST_B1_LATCH: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tx_push && tx_last
      |=> b1_prev == ($past(b1_acc) ^ $past(next_tx.data)))
    else $error("section parity not carried to next frame");

  AST_B1_SLOT: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tx_push && tx_cur.row == 4'h1 && tx_cur.grp == 7'h0 &&
      tx_cur.sts == 4'h0 |-> next_tx.data == b1_prev)
    else $error("B1 slot does not hold previous parity");

  AST_PASS: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tx_push && tx_cat inside {CAT_PAY, CAT_TOH, CAT_K, CAT_H3}
      |-> next_tx.data == tx_in_i.data)
    else $error("transparent byte altered");

  AST_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tx_out_valid_o && !tx_out_ready_i |=> tx_out_valid_o && $stable(tx_out_o))
    else $error("stalled output word changed");

  AST_RX_K: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rx_in_valid_i && rx_cat == CAT_K && rx_k_zero_i
      |=> rx_out_valid_o && rx_out_o.data == ZERO_BYTE && !rx_out_o.mark)
    else $error("receive K byte not zeroed");

  AST_RX_A1: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rx_in_valid_i && rx_in_i.mark |=> rx_out_o.data == A1_VAL)
    else $error("receive A1 not regenerated");

  AST_RX_PAY: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rx_in_valid_i && rx_cat == CAT_PAY
      |=> rx_out_o.mark && rx_out_o.data == $past(rx_in_i.data))
    else $error("receive payload byte not copied");

endmodule

// [tb/stt_fabric_src.sv]
// Purpose: fabric model feeding frame-aligned STS-12 bytes
// Assumes: framer takes a byte on valid and ready
// Notes:   runs until the frame count reaches tgt_i
`timescale 1ns/1ps
module stt_fabric_src
  import stt_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // frame target from the bench
  input  wire logic [3:0] tgt_i,
  output logic [3:0]      frm_o,
  // stream toward the framer
  input  wire logic       ready_i,
  output stt_byte_s       byte_o,
  output logic            valid_o
);
  int         idx;
  logic [7:0] d;
  logic       last;

  // ==========================================================
  // byte pattern; idle bus shows the inverse so it is not stale
  assign d = idx[7:0] ^ idx[15:8] ^ {frm_o, 4'h3};
  assign last = (idx == FRAME_LEN - 1);
  assign byte_o = {valid_o ? d : ~d, valid_o && idx == 0};

  // request held until taken; stops only at a frame boundary
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      idx <= 0;
      frm_o <= 4'h0;
      valid_o <= 1'b0;
    end
    else if (valid_o && ready_i)
    begin
      idx <= last ? 0 : idx + 1;
      if (last)
        frm_o <= frm_o + 4'h1;
      valid_o <= !last || (frm_o + 4'h1 != tgt_i);
    end
    else if (!valid_o)
      valid_o <= (frm_o != tgt_i);
  end
endmodule

// [tb/tb_top.sv]
// Purpose: self-checking bench for the overhead framer
// Assumes: fabric model on transmit, bench drives receive
// Notes:   expected bytes rebuilt from the pattern and parity sums
`timescale 1ns/1ps
module tb_top;
  import stt_pkg::*;
  logic       clk_i, rstn_i, hold;
  stt_byte_s  tx_in_i, tx_out_o, rx_in_i, rx_out_o;
  logic       tx_in_valid_i, tx_in_ready_o, tx_out_valid_o;
  logic       tx_out_ready_i, sync_status_en_i, line_rei_en_i;
  logic       rx_in_valid_i, rx_k_zero_i, rx_out_valid_o;
  logic [3:0] sync_status_i, line_rei_i, tgt, src_frm, ofrm;
  logic [7:0] b1_acc, b1_prev;
  logic [7:0] b2_acc [12];
  logic [7:0] b2_prev [12];
  int         bad_count, tests_run, oidx;
  int         cyc = 0;

  stt_framer uut (.clk_i(clk_i), .rstn_i(rstn_i), .tx_in_i(tx_in_i),
    .tx_in_valid_i(tx_in_valid_i), .tx_in_ready_o(tx_in_ready_o),
    .tx_out_o(tx_out_o), .tx_out_valid_o(tx_out_valid_o),
    .tx_out_ready_i(tx_out_ready_i), .sync_status_en_i(sync_status_en_i),
    .sync_status_i(sync_status_i), .line_rei_en_i(line_rei_en_i),
    .line_rei_i(line_rei_i), .rx_in_i(rx_in_i),
    .rx_in_valid_i(rx_in_valid_i), .rx_k_zero_i(rx_k_zero_i),
    .rx_out_o(rx_out_o), .rx_out_valid_o(rx_out_valid_o));
  stt_fabric_src src (.clk_i(clk_i), .rstn_i(rstn_i), .tgt_i(tgt),
    .frm_o(src_frm), .ready_i(tx_in_ready_o), .byte_o(tx_in_i),
    .valid_o(tx_in_valid_i));

  function automatic logic [7:0] pat(input int i, input logic [3:0] f);
    return i[7:0] ^ i[15:8] ^ {f, 4'h3};
  endfunction

  task automatic check(input string nm, input logic [8:0] seen,
                       input logic [8:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // clock, hang guard and a receiver that stalls one cycle in 7
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    tx_out_ready_i <= !hold && (cyc % 7 != 3);
    if (cyc == 70000)
    begin
      bad_count++;
      conclude();
    end
  end

  // transmit monitor: rebuild each taken byte and the parity sums
  always @(posedge clk_i)
  begin : tx_mon
    int s, g, r;
    logic [7:0] d, e;
    if (rstn_i && tx_out_valid_o === 1'b1 && tx_out_ready_i === 1'b1)
    begin
      s = oidx % 12;
      g = (oidx / 12) % 90;
      r = oidx / 1080;
      d = pat(oidx, ofrm);
      e = d;
      if (r == 0 && g < 2)
        e = (g == 0) ? A1_VAL : A2_VAL;
      if (r == 1 && g == 0)
        e = (s == 0) ? b1_prev : ZERO_BYTE;
      if (r == 4 && g == 0)
        e = b2_prev[s];
      if (r == 8 && g == 0 && s == 0 && sync_status_en_i)
        e = {d[7:4], sync_status_i};
      if (r == 8 && g == 1 && s == 0 && line_rei_en_i)
        e = {d[7:4], line_rei_i};
      check("tx_out", tx_out_o, {e, oidx == 0});
      b1_acc = b1_acc ^ e;
      if (r > 2 || g > 2)
        b2_acc[s] = b2_acc[s] ^ e;
      oidx++;
      if (oidx == FRAME_LEN)
      begin
        b1_prev = b1_acc;
        b2_prev = b2_acc;
        b1_acc = BIP_RST;
        foreach (b2_acc[k]) b2_acc[k] = BIP_RST;
        oidx = 0;
        ofrm++;
      end
    end
  end

  // ==========================================================
  // scenarios
  task automatic t_reset();
    #1;
    check("ready_rst", {8'h00, tx_in_ready_o}, 9'h001);
    check("valid_rst", {8'h00, tx_out_valid_o}, 9'h000);
  endtask

  // frames through, optionally starting with a full output stall
  task automatic t_tx(input logic st, input logic en, input int n);
    int w;
    @(posedge clk_i);
    sync_status_en_i <= en;
    line_rei_en_i <= en;
    hold <= st;
    tgt <= src_frm + n[3:0];
    if (st)
    begin
      repeat (8) @(posedge clk_i);
      #1;
      check("refuse", {8'h00, tx_in_ready_o}, 9'h000);
      check("held", {8'h00, tx_out_valid_o}, 9'h001);
      hold <= 1'b0;
    end
    w = 0;
    do
    begin
      @(posedge clk_i);
      w++;
    end
    while (w < 30000 && (src_frm != tgt || tx_in_valid_i || tx_out_valid_o));
    check("tx_drain", {8'h00, w < 30000}, 9'h001);
    repeat (4) @(posedge clk_i);
  endtask

  // one receive frame with a gap in every nine cycles
  task automatic t_rx(input logic kz);
    int i, n, s, g, r;
    logic v, pv;
    logic [7:0] d;
    logic [8:0] e;
    i = 0;
    pv = 1'b0;
    e = 9'h000;
    @(posedge clk_i);
    rx_k_zero_i <= kz;
    for (n = 0; n < FRAME_LEN * 9 / 8 + 3; n++)
    begin
      @(posedge clk_i);
      v = (n % 9 != 8) && (i < FRAME_LEN);
      d = ~pat(i, 4'h9);
      rx_in_i <= {d, v && i == 0};
      rx_in_valid_i <= v;
      #1;
      check("rx_valid", {8'h00, rx_out_valid_o}, {8'h00, pv});
      if (pv)
        check("rx_out", rx_out_o, e);
      pv = v;
      s = i % 12;
      g = (i / 12) % 90;
      r = i / 1080;
      e = {ZERO_BYTE, 1'b0};
      if (g > 2)
        e = {d, 1'b1};
      if (r == 0 && g < 2)
        e = {(g == 0) ? A1_VAL : A2_VAL, 1'b0};
      if (r == 3 && g == 2)
        e = {d, 1'b0};
      if (r == 4 && g > 0 && g < 3)
        e = {kz ? ZERO_BYTE : d, 1'b0};
      if (v)
        i++;
    end
  endtask

  // ==========================================================
  initial
  begin
    rstn_i = 1'b0;
    hold = 1'b0;
    tgt = 4'h0;
    ofrm = 4'h0;
    oidx = 0;
    tx_out_ready_i = 1'b0;
    sync_status_en_i = 1'b0;
    line_rei_en_i = 1'b0;
    sync_status_i = 4'h5;
    line_rei_i = 4'ha;
    rx_in_i = 9'h000;
    rx_in_valid_i = 1'b0;
    rx_k_zero_i = 1'b0;
    b1_acc = BIP_RST;
    b1_prev = BIP_RST;
    foreach (b2_acc[k]) b2_acc[k] = BIP_RST;
    b2_prev = b2_acc;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_tx(1'b1, 1'b0, 2);
    t_tx(1'b0, 1'b1, 1);
    t_rx(1'b0);
    t_rx(1'b1);
    conclude();
  end
endmodule
